// [rtl/acz_cfg.svh]
// Offsets, field positions, reset values and codes of the channel zero configuration block
`ifndef ACZ_CFG_SVH
`define ACZ_CFG_SVH
`define ACZ_ADR_W          8
`define ACZ_CH0_ADDR       8'h10
`define ACZ_OTHER_ADDR     8'h14
`define ACZ_SEQ_ADDR       8'h18
`define ACZ_CH0_RESET      16'h8001
`define ACZ_OTHER_RESET    15'h0000
`define ACZ_CH0_WMASK      16'hf3ff
`define ACZ_ACTIVE_BIT     15
`define ACZ_SETUP_HI       14
`define ACZ_SETUP_LO       12
`define ACZ_RSVD_HI        11
`define ACZ_RSVD_LO        10
`define ACZ_POS_HI         9
`define ACZ_POS_LO         5
`define ACZ_NEG_HI         4
`define ACZ_NEG_LO         0
`define ACZ_POS_RESET      5'h00
`define ACZ_NEG_RESET      5'h01
`define ACZ_ROUTE_W        23
`define ACZ_POS_MASK       23'h03ffff
`define ACZ_NEG_MASK       23'h67ffff
`define ACZ_CODE_TEMP_P    5'h11
`define ACZ_CODE_TEMP_N    5'h12
`define ACZ_CODE_REF_P     5'h15
`define ACZ_CODE_REF_N     5'h16
`define ACZ_CHAN_W         4
`define ACZ_NUM_CHAN       16
`endif

// [rtl/acz_pkg.sv]
// Types shared by the channel zero configuration block
`include "acz_cfg.svh"
package acz_pkg;
    typedef struct packed {
        logic       active;
        logic [2:0] setup;
        logic [1:0] rsvd;
        logic [4:0] pos;
        logic [4:0] neg;
    } acz_chan_t;

    typedef struct packed {
        logic                    cyc;
        logic                    stb;
        logic                    we;
        logic [`ACZ_ADR_W-1:0]   adr;
        logic [3:0]              sel;
        logic [31:0]             dat;
    } acz_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } acz_wb_rsp_t;

    typedef logic [`ACZ_ROUTE_W-1:0] acz_route_t;
endpackage

// [rtl/acz_route_dec.sv]
// Registered one-hot decoder of an analog input route code
`timescale 1ns/1ps
`include "acz_cfg.svh"
module acz_route_dec #(
    parameter logic [4:0]             RESET_CODE = 5'h00,
    parameter logic [`ACZ_ROUTE_W-1:0] VALID_MASK = '0
) (
    input  wire logic         clk_i,
    input  wire logic         reset_i,
    input  wire logic [4:0]   code_i,
    output acz_pkg::acz_route_t route_o
);
    import acz_pkg::*;
    acz_route_t route_d;
    acz_route_t route_q;

    // Unassigned codes leave every switch open
    genvar g;
    generate
        for (g = 0; g < `ACZ_ROUTE_W; g++) begin : g_sw
            assign route_d[g] = VALID_MASK[g] && (code_i == 5'(g));
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            route_q <= acz_route_t'(1) << RESET_CODE;
        end else begin
            route_q <= route_d;
        end
    end

    assign route_o = route_q;
endmodule

// [rtl/acz_channel_cfg.sv]
// Channel zero configuration register, Wishbone slave and channel sequencer
// Notes on behaviour
// R1: 16-bit register at 0x10, resets 0x8001.
// R2: Bit 15 enables channel zero, default on.
// R3: Several enabled channels are scanned automatically.
// R4: Bits 14:12 pick one of eight setups.
// R5: Picked setup's four registers govern conversions.
// R6: Channels may share or differ in setups.
// R7: Bits 11:10 reserved, read zero, write zero.
// R8: Bits 9:5 route inputs 0-16 positive.
// R9: Positive code 10001 selects temperature sensor.
// R10: Bits 4:0 negative route, reset input one.
// R11: Sequencer ascends, wraps to lowest enabled.
// R12: Software avoids unassigned route codes.
`timescale 1ns/1ps
`include "acz_cfg.svh"
module acz_channel_cfg (
    input  wire logic                   clk_i,
    input  wire logic                   reset_i,
    input  wire acz_pkg::acz_wb_req_t   wb_req_i,
    output acz_pkg::acz_wb_rsp_t        wb_rsp_o,
    input  wire logic                   conv_done_i,
    output logic [`ACZ_CHAN_W-1:0]      seq_chan_o,
    output logic                        seq_valid_o,
    output logic                        chan0_converting_o,
    output logic [2:0]                  chan0_setup_pick_o,
    output acz_pkg::acz_route_t         chan0_positive_route_o,
    output acz_pkg::acz_route_t         chan0_negative_route_o
);
    import acz_pkg::*;

    acz_chan_t                   channel_zero_config_q;
    logic [`ACZ_NUM_CHAN-1:1]    other_enables_q;
    logic [`ACZ_CHAN_W-1:0]      seq_chan_q;
    logic [`ACZ_CHAN_W-1:0]      seq_chan_d;
    logic [2:0]                  setup_pick_q;
    logic                        ack_q;
    logic [31:0]                 rdat_q;
    logic [31:0]                 rdat_d;
    logic [15:0]                 ch0_wdata;
    logic [15:0]                 ch0_bits;
    logic [15:0]                 lane_mask;
    logic [`ACZ_NUM_CHAN-1:0]    chan_enables;
    logic                        bus_req;
    logic                        bus_ack;
    logic                        wr_ch0;
    logic                        wr_other;

    assign bus_req  = wb_req_i.cyc && wb_req_i.stb && !ack_q;
    // Writes land on the edge at which the master samples ack, not one earlier
    assign bus_ack  = wb_req_i.cyc && wb_req_i.stb && ack_q;
    assign wr_ch0   = bus_ack && wb_req_i.we && (wb_req_i.adr == `ACZ_CH0_ADDR);
    assign wr_other = bus_ack && wb_req_i.we && (wb_req_i.adr == `ACZ_OTHER_ADDR);
    assign lane_mask = {{8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};
    assign ch0_bits  = 16'(channel_zero_config_q);
    // Reserved field is dropped on write, so it can never read back set
    assign ch0_wdata = ((wb_req_i.dat[15:0] & lane_mask) | (ch0_bits & ~lane_mask)) & `ACZ_CH0_WMASK; // [R7]
    assign chan_enables = {other_enables_q, channel_zero_config_q.active}; // [R3]

    // One ack per request, dropped in the following cycle
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            channel_zero_config_q <= acz_chan_t'(`ACZ_CH0_RESET); // [R1] [R2] [R4] [R8] [R10]
        end else if (wr_ch0) begin
            channel_zero_config_q <= acz_chan_t'(ch0_wdata); // [R1] [R2] [R4] [R8] [R10]
        end
    end

    // Enables of the other fifteen channels, so the scan has something to visit
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            other_enables_q <= `ACZ_OTHER_RESET;
        end else if (wr_other) begin
            if (wb_req_i.sel[0]) begin
                other_enables_q[7:1] <= wb_req_i.dat[7:1];
            end
            if (wb_req_i.sel[1]) begin
                other_enables_q[15:8] <= wb_req_i.dat[15:8];
            end
        end
    end

    // Unmapped addresses read zero and ignore writes
    always_comb begin
        rdat_d = 32'h0;
        case (wb_req_i.adr)
            `ACZ_CH0_ADDR: begin
                rdat_d = {16'h0, ch0_bits}; // [R1] [R7]
            end
            `ACZ_OTHER_ADDR: begin
                rdat_d = {16'h0, other_enables_q, 1'b0};
            end
            `ACZ_SEQ_ADDR: begin
                rdat_d = {26'h0, chan0_converting_o, seq_valid_o, seq_chan_q};
            end
            default: begin
                rdat_d = 32'h0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdat_q <= 32'h0;
        end else if (bus_req && !wb_req_i.we) begin
            rdat_q <= rdat_d;
        end else if (bus_req) begin
            rdat_q <= 32'h0;
        end
    end

    assign wb_rsp_o.ack = ack_q;
    assign wb_rsp_o.dat = rdat_q;

    // Next enabled channel above the current one, else the lowest enabled
    function automatic logic [`ACZ_CHAN_W-1:0] acz_next_chan(
        input logic [`ACZ_NUM_CHAN-1:0] en,
        input logic [`ACZ_CHAN_W-1:0]   cur
    );
        logic [`ACZ_CHAN_W-1:0] r;
        r = cur;
        for (int i = `ACZ_NUM_CHAN - 1; i >= 0; i--) begin
            if (en[i]) begin
                r = `ACZ_CHAN_W'(i);
            end
        end
        for (int i = `ACZ_NUM_CHAN - 1; i >= 0; i--) begin
            if (en[i] && (i > int'(cur))) begin
                r = `ACZ_CHAN_W'(i);
            end
        end
        return r;
    endfunction

    assign seq_chan_d = acz_next_chan(chan_enables, seq_chan_q); // [R11]

    // Step only at the end of a conversion; disabling channel zero mid-way drops chan0_converting_o at once
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            seq_chan_q <= `ACZ_CHAN_W'(0);
        end else if (conv_done_i && (chan_enables != '0)) begin
            seq_chan_q <= seq_chan_d; // [R3] [R11]
        end
    end

    // Setup index drives the bank select of the four setup registers
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            setup_pick_q <= 3'h0;
        end else begin
            setup_pick_q <= channel_zero_config_q.setup; // [R5] [R6]
        end
    end

    assign seq_chan_o         = seq_chan_q;
    assign seq_valid_o        = (chan_enables != '0);
    assign chan0_converting_o = seq_valid_o && (seq_chan_q == `ACZ_CHAN_W'(0)) && channel_zero_config_q.active;
    assign chan0_setup_pick_o = setup_pick_q;

    acz_route_dec #(
        .RESET_CODE (`ACZ_POS_RESET),
        .VALID_MASK (`ACZ_POS_MASK)
    ) u_pos_dec (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .code_i  (channel_zero_config_q.pos), // [R8] [R9] [R12]
        .route_o (chan0_positive_route_o)
    );

    acz_route_dec #(
        .RESET_CODE (`ACZ_NEG_RESET),
        .VALID_MASK (`ACZ_NEG_MASK)
    ) u_neg_dec (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .code_i  (channel_zero_config_q.neg), // [R10] [R12]
        .route_o (chan0_negative_route_o)
    );

    property p_reset_value;
        @(posedge clk_i) ($past(reset_i) && !reset_i) |-> (ch0_bits == `ACZ_CH0_RESET);
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("ch0 reset value wrong"); // [R1]

    property p_read_back;
        @(posedge clk_i) disable iff (reset_i)
        (bus_req && !wb_req_i.we && wb_req_i.adr == `ACZ_CH0_ADDR) ##1 1'b1
        |-> ack_q && (wb_rsp_o.dat == {16'h0, $past(ch0_bits)});
    endproperty
    a_read_back: assert property (p_read_back) else $error("ch0 read data wrong"); // [R1]

    property p_ack_single;
        @(posedge clk_i) disable iff (reset_i) ack_q |=> !ack_q;
    endproperty
    a_ack_single: assert property (p_ack_single) else $error("ack held two cycles"); // [R1]

    property p_active_write;
        @(posedge clk_i) disable iff (reset_i)
        (wr_ch0 && wb_req_i.sel[1]) |=> (channel_zero_config_q.active == $past(wb_req_i.dat[15]));
    endproperty
    a_active_write: assert property (p_active_write) else $error("enable bit not written"); // [R2]

    property p_rsvd_zero;
        @(posedge clk_i) disable iff (reset_i) channel_zero_config_q.rsvd == 2'h0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits set"); // [R7]

    property p_setup_follow;
        @(posedge clk_i) disable iff (reset_i)
        (wr_ch0 && wb_req_i.sel[1]) |=> ##1 (chan0_setup_pick_o == $past(wb_req_i.dat[14:12], 2));
    endproperty
    a_setup_follow: assert property (p_setup_follow) else $error("setup pick not applied"); // [R4] [R5]

    property p_pos_route;
        @(posedge clk_i) disable iff (reset_i)
        (channel_zero_config_q.pos <= `ACZ_CODE_TEMP_P) |=>
        (chan0_positive_route_o == (acz_route_t'(1) << $past(channel_zero_config_q.pos)));
    endproperty
    a_pos_route: assert property (p_pos_route) else $error("positive route wrong"); // [R8] [R9]

    property p_neg_ref;
        @(posedge clk_i) disable iff (reset_i)
        (channel_zero_config_q.neg == `ACZ_CODE_REF_P) |=>
        (chan0_negative_route_o == (acz_route_t'(1) << `ACZ_CODE_REF_P));
    endproperty
    a_neg_ref: assert property (p_neg_ref) else $error("negative reference route wrong"); // [R10]

    property p_scan_moves;
        @(posedge clk_i) disable iff (reset_i)
        (conv_done_i && !$onehot0(chan_enables) && chan_enables[seq_chan_q]) |=> (seq_chan_q != $past(seq_chan_q));
    endproperty
    a_scan_moves: assert property (p_scan_moves) else $error("scan did not advance"); // [R3]

    property p_scan_order;
        @(posedge clk_i) disable iff (reset_i)
        (conv_done_i && chan_enables != '0) |=>
        chan_enables[seq_chan_q] && ((seq_chan_q > $past(seq_chan_q)) ||
        (($past(chan_enables) & ((16'h1 << seq_chan_q) - 16'h1)) == 16'h0));
    endproperty
    a_scan_order: assert property (p_scan_order) else $error("scan order wrong"); // [R11]

    property p_ack_follows;
        @(posedge clk_i) disable iff (reset_i) bus_req |=> ack_q;
    endproperty
    a_ack_follows: assert property (p_ack_follows) else $error("request not acknowledged"); // [R1]

    property p_write_full;
        @(posedge clk_i) disable iff (reset_i)
        (wr_ch0 && wb_req_i.sel[1:0] == 2'h3) |=> (ch0_bits == ($past(wb_req_i.dat[15:0]) & `ACZ_CH0_WMASK));
    endproperty
    a_write_full: assert property (p_write_full) else $error("full write not stored"); // [R1] [R7]

    property p_byte_keep;
        @(posedge clk_i) disable iff (reset_i)
        (wr_ch0 && !wb_req_i.sel[1]) |=> (ch0_bits[15:8] == $past(ch0_bits[15:8]));
    endproperty
    a_byte_keep: assert property (p_byte_keep) else $error("unselected lane changed"); // [R1]

    property p_cfg_hold;
        @(posedge clk_i) disable iff (reset_i) !wr_ch0 |=> (ch0_bits == $past(ch0_bits));
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("register changed without write"); // [R1] [R2]

    property p_neg_route;
        @(posedge clk_i) disable iff (reset_i)
        (channel_zero_config_q.neg <= `ACZ_CODE_TEMP_N) |=>
        (chan0_negative_route_o == (acz_route_t'(1) << $past(channel_zero_config_q.neg)));
    endproperty
    a_neg_route: assert property (p_neg_route) else $error("negative route wrong"); // [R10]

    property p_neg_ref_n;
        @(posedge clk_i) disable iff (reset_i)
        (channel_zero_config_q.neg == `ACZ_CODE_REF_N) |=>
        (chan0_negative_route_o == (acz_route_t'(1) << `ACZ_CODE_REF_N));
    endproperty
    a_neg_ref_n: assert property (p_neg_ref_n) else $error("negative reference minus route wrong"); // [R10]

    property p_pos_onehot;
        @(posedge clk_i) disable iff (reset_i) $onehot0(chan0_positive_route_o);
    endproperty
    a_pos_onehot: assert property (p_pos_onehot) else $error("two positive switches closed"); // [R8]

    property p_seq_hold;
        @(posedge clk_i) disable iff (reset_i) !conv_done_i |=> (seq_chan_q == $past(seq_chan_q));
    endproperty
    a_seq_hold: assert property (p_seq_hold) else $error("scan moved without conversion end"); // [R3]

    property p_pick_reset;
        @(posedge clk_i) reset_i |=> (chan0_setup_pick_o == 3'h0);
    endproperty
    a_pick_reset: assert property (p_pick_reset) else $error("setup pick not reset"); // [R4]

    property p_write_rdat_zero;
        @(posedge clk_i) disable iff (reset_i) (bus_req && wb_req_i.we) |=> (wb_rsp_o.dat == 32'h0);
    endproperty
    a_write_rdat_zero: assert property (p_write_rdat_zero) else $error("write returned data"); // [R1]

    property p_unmapped_zero;
        @(posedge clk_i) disable iff (reset_i)
        (bus_req && !wb_req_i.we && wb_req_i.adr != `ACZ_CH0_ADDR && wb_req_i.adr != `ACZ_OTHER_ADDR &&
        wb_req_i.adr != `ACZ_SEQ_ADDR) |=> (wb_rsp_o.dat == 32'h0);
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero"); // [R1]

    property p_single_stays;
        @(posedge clk_i) disable iff (reset_i)
        (conv_done_i && $onehot(chan_enables) && chan_enables[seq_chan_q]) |=> (seq_chan_q == $past(seq_chan_q));
    endproperty
    a_single_stays: assert property (p_single_stays) else $error("lone channel left"); // [R11]

    property p_idle_no_step;
        @(posedge clk_i) disable iff (reset_i)
        (conv_done_i && chan_enables == '0) |=> (seq_chan_q == $past(seq_chan_q));
    endproperty
    a_idle_no_step: assert property (p_idle_no_step) else $error("scan moved with no channel enabled"); // [R3]
endmodule

// [testbench/adc_channel_zero_config_test.sv]
// Self-checking bench for the channel zero configuration block
`timescale 1ns/1ps
`include "acz_cfg.svh"
module adc_channel_zero_config_test;
    import acz_pkg::*;
    typedef struct packed {
        logic       en;
        logic [2:0] su;
        logic [4:0] p;
        logic [4:0] n;
    } acz_row_t;
    logic                   clk_i = 1'b0;
    logic                   reset_i = 1'b1;
    acz_wb_req_t            req = '0;
    acz_wb_rsp_t            rsp;
    logic                   conv_done = 1'b0;
    logic [`ACZ_CHAN_W-1:0] seq_chan;
    logic                   seq_valid;
    logic                   converting;
    logic [2:0]             setup;
    acz_route_t             pos_route;
    acz_route_t             neg_route;
    int                     n_fail = 0;
    int                     comparisons = 0;
    logic [15:0]            rd;
    logic [15:0]            w;
    // Every setup and the sensor and reference codes; reserved bits zero, no unassigned codes
    acz_row_t               rows [8] = '{'{1'h0, 3'h7, 5'h10, 5'h00}, '{1'h1, 3'h1, 5'h11, 5'h12},
                                         '{1'h1, 3'h2, 5'h05, 5'h15}, '{1'h0, 3'h3, 5'h03, 5'h16},
                                         '{1'h1, 3'h4, 5'h0f, 5'h10}, '{1'h1, 3'h5, 5'h00, 5'h00},
                                         '{1'h1, 3'h6, 5'h01, 5'h01}, '{1'h1, 3'h0, 5'h08, 5'h02}};

    always #5 clk_i = ~clk_i;

    acz_channel_cfg dut_u (
        .clk_i                  (clk_i),
        .reset_i                (reset_i),
        .wb_req_i               (req),
        .wb_rsp_o               (rsp),
        .conv_done_i            (conv_done),
        .seq_chan_o             (seq_chan),
        .seq_valid_o            (seq_valid),
        .chan0_converting_o     (converting),
        .chan0_setup_pick_o     (setup),
        .chan0_positive_route_o (pos_route),
        .chan0_negative_route_o (neg_route)
    );

    task automatic conclude();
        if (n_fail == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One classic cycle; held until ack is sampled, then one idle cycle follows
    task automatic bus(input logic we, input logic [7:0] adr, input logic [15:0] d, input logic [3:0] sel = 4'h3);
        int k;
        @(posedge clk_i);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: {16'h0000, d}};
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (rsp.ack !== 1'b1 && k < 20);
        if (rsp.ack !== 1'b1) begin
            n_fail++;
            conclude();
        end
        rd = rsp.dat[15:0];
        chk("read_upper", rsp.dat[31:16], 32'h0);
        req <= '0;
    endtask

    task automatic step(input logic [3:0] exp, input logic conv);
        @(posedge clk_i);
        conv_done <= 1'b1;
        @(posedge clk_i);
        conv_done <= 1'b0;
        @(negedge clk_i);
        chk("seq_chan", seq_chan, exp);
        chk("chan0_converting", converting, conv);
    endtask

    initial begin
        #500000;
        n_fail++;
        conclude();
    end

    initial begin
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        @(negedge clk_i);
        chk("setup", setup, 32'h0);
        chk("pos_route", pos_route, 32'h1);
        chk("neg_route", neg_route, 32'h2);
        chk("seq_valid", seq_valid, 32'h1);
        bus(1'b0, 8'h10, 16'h0000);
        chk("cfg_reset", rd, 32'h8001);
        foreach (rows[i]) begin
            w = {rows[i].en, rows[i].su, 2'b00, rows[i].p, rows[i].n};
            bus(1'b1, 8'h10, w);
            bus(1'b0, 8'h10, 16'h0000);
            @(negedge clk_i);
            chk("cfg_read", rd, w);
            chk("setup", setup, rows[i].su);
            chk("pos_route", pos_route, 32'h1 << rows[i].p);
            chk("neg_route", neg_route, 32'h1 << rows[i].n);
            chk("seq_valid", seq_valid, rows[i].en);
            chk("chan0_converting", converting, rows[i].en);
        end
        // Low byte lane only: the upper half must survive
        bus(1'b1, 8'h10, 16'h0061, 4'h1);
        bus(1'b0, 8'h10, 16'h0000);
        chk("cfg_byte", rd, 32'h8161);
        chk("pos_route", pos_route, 32'h800);
        bus(1'b1, 8'h14, 16'h0089);
        bus(1'b0, 8'h14, 16'h0000);
        chk("other_en", rd, 32'h0088);
        step(4'h3, 1'b0);
        step(4'h7, 1'b0);
        step(4'h0, 1'b1);
        step(4'h3, 1'b0);
        bus(1'b1, 8'h18, 16'hffff);
        bus(1'b0, 8'h18, 16'h0000);
        chk("status", rd, 32'h0013);
        bus(1'b1, 8'h14, 16'h0000);
        step(4'h0, 1'b1);
        step(4'h0, 1'b1);
        bus(1'b1, 8'h10, 16'h0161);
        step(4'h0, 1'b0);
        chk("seq_valid", seq_valid, 32'h0);
        bus(1'b1, 8'h40, 16'hffff);
        bus(1'b0, 8'h40, 16'h0000);
        chk("unmapped", rd, 32'h0);
        bus(1'b0, 8'h10, 16'h0000);
        chk("cfg_kept", rd, 32'h0161);
        // Second reset in mid-run restores defaults
        @(posedge clk_i);
        reset_i <= 1'b1;
        @(posedge clk_i);
        reset_i <= 1'b0;
        @(negedge clk_i);
        chk("pos_route", pos_route, 32'h1);
        chk("neg_route", neg_route, 32'h2);
        chk("chan0_converting", converting, 32'h1);
        bus(1'b0, 8'h10, 16'h0000);
        chk("cfg_reset", rd, 32'h8001);
        conclude();
    end
endmodule
